// >>> verilog/rwsc_pkg.sv
// Constants shared by the reset, watchdog and suspend sequencer.
// Assumes a 250 MHz core clock and an 8-bit I/O space driven by the CPU.
package rwsc_pkg;

  // ********************************************************************
  // I/O offsets and field positions
  // ********************************************************************
  localparam logic [7:0] RWSC_ADDR_USB_IRQ_EN  = 8'h20;
  localparam logic [7:0] RWSC_ADDR_WDOG_RESTART = 8'h26;
  localparam logic [7:0] RWSC_ADDR_STATUS_CTRL = 8'hFF;

  localparam int RWSC_BIT_BUS_RST_EN = 0;
  localparam int RWSC_BIT_RUN        = 0;
  localparam int RWSC_BIT_IRQ_SENSE  = 2;
  localparam int RWSC_BIT_SUSPEND    = 3;
  localparam int RWSC_BIT_POR_FLAG   = 4;
  localparam int RWSC_BIT_WDOG_FLAG  = 6;

  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [7:0] RWSC_STATUS_POR_VAL  = 8'h11;
  localparam logic [7:0] RWSC_STATUS_WDOG_VAL = 8'h41;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int RWSC_CLK_MHZ      = 250;
  localparam int RWSC_LOCK_MS      = 1;
  localparam int RWSC_SEMI_WAIT_MS = 95;
  localparam int RWSC_WDOG_MS      = 8;
  localparam int RWSC_WDOG_HOLD_MS = 2;
  localparam int RWSC_SETTLE_MS    = 1;
  localparam int RWSC_LOCK_CYC      = RWSC_LOCK_MS * RWSC_CLK_MHZ * 1000;
  localparam int RWSC_SEMI_WAIT_CYC = RWSC_SEMI_WAIT_MS * RWSC_CLK_MHZ * 1000;
  localparam int RWSC_WDOG_CYC      = RWSC_WDOG_MS * RWSC_CLK_MHZ * 1000;
  localparam int RWSC_WDOG_HOLD_CYC = RWSC_WDOG_HOLD_MS * RWSC_CLK_MHZ * 1000;
  localparam int RWSC_SETTLE_CYC    = RWSC_SETTLE_MS * RWSC_CLK_MHZ * 1000;
  localparam int RWSC_CNT_W         = 25;

  typedef enum logic [2:0] {
    RWSC_SEMI_LOCK,
    RWSC_SEMI_WAIT,
    RWSC_RUN,
    RWSC_SUSP,
    RWSC_WAKE_OSC,
    RWSC_WAKE_SETTLE,
    RWSC_WDOG_HOLD
  } rwsc_state_t;

endpackage

// >>> verilog/rwsc_sync.sv
// Two-stage synchroniser, one stage pair per bit.
// Assumes the inputs are asynchronous levels; pulses shorter than a clock may be lost.
`timescale 1ns/10ps
module rwsc_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // ******************************************************************
  // Synchroniser stages
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // The first stage feeds only the second stage, to contain metastability.
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule // rwsc_sync

// >>> verilog/rwsc_ctrl.sv
// Reset, watchdog and suspend sequencer of a USB microcontroller.
// Assumes nrst is the power-on reset and the CPU decodes its own I/O strobes.
`timescale 1ns/10ps
module rwsc_ctrl #(
  parameter int LOCK_CYC      = rwsc_pkg::RWSC_LOCK_CYC,
  parameter int SEMI_WAIT_CYC = rwsc_pkg::RWSC_SEMI_WAIT_CYC,
  parameter int WDOG_CYC      = rwsc_pkg::RWSC_WDOG_CYC,
  parameter int WDOG_HOLD_CYC = rwsc_pkg::RWSC_WDOG_HOLD_CYC,
  parameter int SETTLE_CYC    = rwsc_pkg::RWSC_SETTLE_CYC
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  input  wire logic       usb_bus_reset,
  input  wire logic       usb_activity,
  input  wire logic       gpio_wake_irq,
  input  wire logic       osc_stable,
  input  wire logic       global_irq_en,
  input  wire logic       bus_reset_irq_ack,
  input  wire logic       instr_done,
  output logic            cpu_rst,
  output logic            osc_en,
  output logic            blk_clk_en,
  output logic            usb_addr_clr,
  output logic            bus_reset_irq,
  output logic            irq_hold
);

  localparam int RWSC_CNT_W = rwsc_pkg::RWSC_CNT_W;

  logic [3:0]                     pin_sync;
  logic                           bus_rst_s;
  logic                           usb_act_s;
  logic                           gpio_wake_s;
  logic                           osc_ok_s;
  rwsc_pkg::rwsc_state_t          state;
  rwsc_pkg::rwsc_state_t          next_state;
  logic [rwsc_pkg::RWSC_CNT_W-1:0] tmr;
  logic [rwsc_pkg::RWSC_CNT_W-1:0] next_tmr;
  logic [rwsc_pkg::RWSC_CNT_W-1:0] wdog_cnt;
  logic [7:0]                     status;
  logic                           bus_rst_en;
  logic                           bus_rst_pend;
  logic                           wr_status;
  logic                           wr_restart;
  logic                           wdog_expire;
  logic                           early_start;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  rwsc_sync #(
    .W (4)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({osc_stable, gpio_wake_irq, usb_activity, usb_bus_reset}),
    .sync_out (pin_sync)
  );

  assign bus_rst_s   = pin_sync[0];
  assign usb_act_s   = pin_sync[1];
  assign gpio_wake_s = pin_sync[2];
  assign osc_ok_s    = pin_sync[3];

  // I/O write decode; the CPU only issues writes while it runs.
  assign wr_status  = io_wr && (io_addr == rwsc_pkg::RWSC_ADDR_STATUS_CTRL);
  assign wr_restart = io_wr && (io_addr == rwsc_pkg::RWSC_ADDR_WDOG_RESTART);

  // The watchdog expires on the cycle its count reaches WDOG_CYC - 1.
  assign wdog_expire = (state == rwsc_pkg::RWSC_RUN) &&
                       (wdog_cnt == RWSC_CNT_W'(WDOG_CYC - 1));
  assign early_start = (state == rwsc_pkg::RWSC_SEMI_WAIT) && bus_rst_s;

  // ******************************************************************
  // Sequencer next state
  // ******************************************************************
  // Every timed state counts tmr up from zero and leaves at its limit; RWSC_SEMI_WAIT also leaves early on bus reset, RWSC_WAKE_SETTLE only once the run bit is set.
  always_comb begin
    next_state = state;
    next_tmr   = tmr + 1'b1;
    case (state)
      rwsc_pkg::RWSC_SEMI_LOCK: begin
        // Bus reset is deliberately not looked at here.
        if (tmr == RWSC_CNT_W'(LOCK_CYC - 1)) begin
          next_state = rwsc_pkg::RWSC_SEMI_WAIT;
          next_tmr   = '0;
        end
      end
      rwsc_pkg::RWSC_SEMI_WAIT: begin
        if (bus_rst_s) begin
          next_state = rwsc_pkg::RWSC_RUN;
          next_tmr   = '0;
        end else if (tmr == RWSC_CNT_W'(SEMI_WAIT_CYC - 1)) begin
          next_state = rwsc_pkg::RWSC_RUN;
          next_tmr   = '0;
        end
      end
      rwsc_pkg::RWSC_RUN: begin
        next_tmr = '0;
        if (wdog_expire) begin
          next_state = rwsc_pkg::RWSC_WDOG_HOLD;
        end else if (wr_status && io_wdata[rwsc_pkg::RWSC_BIT_SUSPEND]) begin
          next_state = rwsc_pkg::RWSC_SUSP;
        end
      end
      rwsc_pkg::RWSC_SUSP: begin
        next_tmr = '0;
        if (gpio_wake_s || usb_act_s) begin
          next_state = rwsc_pkg::RWSC_WAKE_OSC;
        end
      end
      rwsc_pkg::RWSC_WAKE_OSC: begin
        next_tmr = '0;
        if (osc_ok_s) begin
          next_state = rwsc_pkg::RWSC_WAKE_SETTLE;
        end
      end
      rwsc_pkg::RWSC_WAKE_SETTLE: begin
        // Without the run bit the CPU stays stopped after the wait.
        if (tmr == RWSC_CNT_W'(SETTLE_CYC - 1) && status[rwsc_pkg::RWSC_BIT_RUN]) begin
          next_state = rwsc_pkg::RWSC_RUN;
          next_tmr   = '0;
        end else if (tmr == RWSC_CNT_W'(SETTLE_CYC - 1)) begin
          next_tmr = tmr;
        end
      end
      rwsc_pkg::RWSC_WDOG_HOLD: begin
        if (tmr == RWSC_CNT_W'(WDOG_HOLD_CYC - 1)) begin
          next_state = rwsc_pkg::RWSC_RUN;
          next_tmr   = '0;
        end
      end
      default: begin
        next_state = rwsc_pkg::RWSC_SEMI_LOCK;
        next_tmr   = '0;
      end
    endcase
  end

  // ******************************************************************
  // Sequencer state and timer
  // ******************************************************************
  // Power-on reset always restarts the full semi-suspend sequence.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= rwsc_pkg::RWSC_SEMI_LOCK;
      tmr   <= '0;
    end else begin
      state <= next_state;
      tmr   <= next_tmr;
    end
  end

  // ******************************************************************
  // Watchdog counter
  // ******************************************************************
  // Counts only while the CPU runs; suspend and reset hold it at zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdog_cnt <= '0;
    end else if (wr_restart || state != rwsc_pkg::RWSC_RUN || wdog_expire) begin
      wdog_cnt <= '0;
    end else begin
      wdog_cnt <= wdog_cnt + 1'b1;
    end
  end

  // ******************************************************************
  // Processor status and control register
  // ******************************************************************
  // Reset-cause flags only clear by a written zero, so a stale flag cannot reappear.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= rwsc_pkg::RWSC_STATUS_POR_VAL;
    end else if (wdog_expire) begin
      status <= rwsc_pkg::RWSC_STATUS_WDOG_VAL |
                (status & (8'h01 << rwsc_pkg::RWSC_BIT_POR_FLAG));
    end else if (state == rwsc_pkg::RWSC_WAKE_SETTLE && next_state == rwsc_pkg::RWSC_RUN) begin
      status[rwsc_pkg::RWSC_BIT_SUSPEND] <= 1'b0;
    end else if (wr_status && state == rwsc_pkg::RWSC_RUN) begin
      status <= io_wdata & (status | ~((8'h01 << rwsc_pkg::RWSC_BIT_POR_FLAG) |
                                       (8'h01 << rwsc_pkg::RWSC_BIT_WDOG_FLAG)));
    end
  end

  // ******************************************************************
  // Bus reset interrupt enable and pending flag
  // ******************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_rst_en <= 1'b0;
    end else if (wdog_expire) begin
      bus_rst_en <= 1'b0;
    end else if (io_wr && io_addr == rwsc_pkg::RWSC_ADDR_USB_IRQ_EN) begin
      bus_rst_en <= io_wdata[rwsc_pkg::RWSC_BIT_BUS_RST_EN];
    end
  end

  // A new bus reset wins over an acknowledge in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_rst_pend <= 1'b0;
    end else if (early_start || (state == rwsc_pkg::RWSC_RUN && bus_rst_s)) begin
      bus_rst_pend <= 1'b1;
    end else if (bus_reset_irq_ack || state == rwsc_pkg::RWSC_WDOG_HOLD) begin
      bus_rst_pend <= 1'b0;
    end
  end

  // ******************************************************************
  // Read data
  // ******************************************************************
  // The restart register is write-only and reads as zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        rwsc_pkg::RWSC_ADDR_STATUS_CTRL: io_rdata <= status;
        rwsc_pkg::RWSC_ADDR_USB_IRQ_EN:  io_rdata <= {7'h00, bus_rst_en};
        default:                         io_rdata <= 8'h00;
      endcase
    end
  end

  // ******************************************************************
  // Clock, CPU and USB controls
  // ******************************************************************
  // Registered from the next state so each control changes with the state itself.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rst      <= 1'b1;
      osc_en       <= 1'b1;
      blk_clk_en   <= 1'b1;
      usb_addr_clr <= 1'b1;
    end else begin
      cpu_rst      <= next_state == rwsc_pkg::RWSC_SEMI_LOCK ||
                      next_state == rwsc_pkg::RWSC_SEMI_WAIT ||
                      next_state == rwsc_pkg::RWSC_WDOG_HOLD;
      osc_en       <= next_state != rwsc_pkg::RWSC_SUSP;
      blk_clk_en   <= next_state != rwsc_pkg::RWSC_SUSP &&
                      next_state != rwsc_pkg::RWSC_WAKE_OSC &&
                      next_state != rwsc_pkg::RWSC_WAKE_SETTLE;
      usb_addr_clr <= next_state == rwsc_pkg::RWSC_SEMI_LOCK ||
                      next_state == rwsc_pkg::RWSC_SEMI_WAIT ||
                      next_state == rwsc_pkg::RWSC_WDOG_HOLD;
    end
  end

  // ******************************************************************
  // Interrupt gating after wake and reset
  // ******************************************************************
  // Holding interrupts until one instruction retires keeps the post-suspend order.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_hold <= 1'b0;
    end else if (state == rwsc_pkg::RWSC_WAKE_SETTLE && next_state == rwsc_pkg::RWSC_RUN) begin
      irq_hold <= 1'b1;
    end else if (instr_done) begin
      irq_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_reset_irq <= 1'b0;
    end else begin
      bus_reset_irq <= bus_rst_pend && bus_rst_en && global_irq_en &&
                       !irq_hold && state == rwsc_pkg::RWSC_RUN &&
                       !wr_status;
    end
  end

endmodule // rwsc_ctrl

// >>> test/rwsc_fw_model.sv
// Firmware and oscillator stand-in on the far side of the sequencer.
// Assumes the sequencer's clock and power-on reset; answers each request promptly.
`timescale 1ns/10ps
module rwsc_fw_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic osc_en,
  input  wire logic bus_reset_irq,
  input  wire logic irq_hold,
  output logic      osc_stable,
  output logic      bus_reset_irq_ack,
  output logic      instr_done
);
  logic [2:0] osc_cnt;
  logic [1:0] hold_dly;

  // ********************************************************************
  // Oscillator and CPU behaviour
  // ********************************************************************
  // The oscillator needs eight cycles after enable before it reports stable.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_cnt    <= 3'h0;
      osc_stable <= 1'h0;
    end else if (!osc_en) begin
      osc_cnt    <= 3'h0;
      osc_stable <= 1'h0;
    end else begin
      osc_cnt    <= (osc_cnt == 3'h7) ? osc_cnt : osc_cnt + 3'h1;
      osc_stable <= (osc_cnt == 3'h7);
    end
  end

  // The CPU acknowledges a request one cycle after seeing it and retires
  // an instruction three cycles after the hold appears, so the hold is seen.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_reset_irq_ack <= 1'h0;
      instr_done        <= 1'h0;
      hold_dly          <= 2'h0;
    end else begin
      bus_reset_irq_ack <= bus_reset_irq && !bus_reset_irq_ack;
      hold_dly          <= {hold_dly[0], irq_hold};
      instr_done        <= hold_dly[1] && !instr_done;
    end
  end
endmodule  // rwsc_fw_model

// >>> test/rwsc_ctrl_properties.sv
// Concurrent checks on the ports of the reset, watchdog and suspend sequencer.
// Assumes it is bound to rwsc_ctrl with the same count parameters.
`timescale 1ns/10ps
module rwsc_ctrl_properties #(
  parameter int LOCK_CYC      = 20,
  parameter int SEMI_WAIT_CYC = 40,
  parameter int WDOG_CYC      = 60,
  parameter int WDOG_HOLD_CYC = 30,
  parameter int SETTLE_CYC    = 20
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] io_addr,
  input wire logic       io_wr,
  input wire logic       usb_activity,
  input wire logic       gpio_wake_irq,
  input wire logic       osc_stable,
  input wire logic       global_irq_en,
  input wire logic       cpu_rst,
  input wire logic       osc_en,
  input wire logic       blk_clk_en,
  input wire logic       usb_addr_clr,
  input wire logic       bus_reset_irq,
  input wire logic       irq_hold
);
  logic por_ph;
  logic wake_any;
  int   st_cnt;
  int   wd_cnt;
  int   hd_cnt;
  int   sb_cnt;

  // ********************************************************************
  // Helper counters
  // ********************************************************************
  // Either wake source, sampled as one signal.
  assign wake_any = usb_activity | gpio_wake_irq;

  // Start-up phase and its length in edges since reset release.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      por_ph <= 1'h1;
      st_cnt <= 0;
    end else begin
      por_ph <= por_ph && cpu_rst;
      st_cnt <= por_ph ? st_cnt + 1 : st_cnt;
    end
  end

  // Running cycles since the last restart; the bounds carry slack, though
  // blk_clk_en and cpu_rst change in the same cycle as the internal state.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_cnt <= 0;
    end else begin
      wd_cnt <= (cpu_rst || !blk_clk_en || (io_wr &&
                 io_addr == rwsc_pkg::RWSC_ADDR_WDOG_RESTART)) ? 0 : wd_cnt + 1;
    end
  end

  // Length of a reset pulse, and stable-oscillator time while blocks are off.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hd_cnt <= 0;
      sb_cnt <= 0;
    end else begin
      hd_cnt <= cpu_rst ? hd_cnt + 1 : 0;
      sb_cnt <= (osc_stable && !blk_clk_en) ? sb_cnt + 1 : 0;
    end
  end

  // ********************************************************************
  // Properties
  // ********************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_rst_fall;
    $fell(cpu_rst);
  endsequence
  sequence s_wdog_rise;
    $rose(cpu_rst) && !por_ph;
  endsequence

  a_semi_hold_cpu: assert property (por_ph && st_cnt < LOCK_CYC |-> cpu_rst)
    else $error("cpu released inside the uninterruptible interval");
  a_semi_length: assert property (s_rst_fall ##0 por_ph |->
    st_cnt > LOCK_CYC && st_cnt <= LOCK_CYC + SEMI_WAIT_CYC + 1)
    else $error("start-up interval has the wrong length");
  a_addr_tracks_rst: assert property (usb_addr_clr == cpu_rst)
    else $error("device address clear differs from cpu reset");
  a_wdog_not_early: assert property (s_wdog_rise |-> wd_cnt >= WDOG_CYC - 1)
    else $error("watchdog reset before its timeout");
  a_wdog_not_late: assert property (!cpu_rst |-> wd_cnt <= WDOG_CYC + 2)
    else $error("watchdog failed to roll over");
  a_wdog_hold_len: assert property (s_rst_fall ##0 !por_ph |->
    hd_cnt == WDOG_HOLD_CYC)
    else $error("watchdog reset has the wrong length");
  a_susp_all_off: assert property (!osc_en |-> !blk_clk_en && !cpu_rst)
    else $error("blocks running while oscillator is off");
  a_wake_has_cause: assert property ($rose(osc_en) |-> $past(wake_any, 2))
    else $error("oscillator restarted without a wake event");
  a_settle_time: assert property ($rose(blk_clk_en) |-> sb_cnt >= SETTLE_CYC)
    else $error("blocks restarted before the settle time");
  a_hold_blocks_irq: assert property (irq_hold |-> !bus_reset_irq)
    else $error("interrupt raised before the first instruction after wake");
  a_irq_gated: assert property (bus_reset_irq |-> $past(global_irq_en) && !cpu_rst)
    else $error("bus reset interrupt raised while globally disabled");
endmodule  // rwsc_ctrl_properties

// >>> test/test_reset_watchdog_suspend_ctrl.sv
// Self-checking bench for the reset, watchdog and suspend sequencer.
// Assumes shortened counts and the firmware model on the far side.
`timescale 1ns/10ps
module test_reset_watchdog_suspend_ctrl;
  localparam int LK = 20;
  localparam int SW = 40;
  localparam int WD = 60;
  localparam int HD = 30;
  localparam int ST = 20;
  typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} rwsc_row_t;

  logic       clk, nrst, io_wr, io_rd, usb_bus_reset, usb_activity, gpio_wake_irq;
  logic       osc_stable, global_irq_en, bus_reset_irq_ack, instr_done, cpu_rst, osc_en;
  logic       blk_clk_en, usb_addr_clr, bus_reset_irq, irq_hold;
  logic [7:0] io_addr, io_wdata, io_rdata, rd;
  int         mismatches, comparisons, cycles, n;
  rwsc_row_t  rows [10] = '{'{1'h0, 8'hFF, 8'h00, 8'h11}, '{1'h0, 8'h20, 8'h00, 8'h00},
    '{1'h0, 8'h26, 8'h00, 8'h00}, '{1'h0, 8'h10, 8'h00, 8'h00}, '{1'h1, 8'h20, 8'h01, 8'h00},
    '{1'h0, 8'h20, 8'h00, 8'h01}, '{1'h1, 8'hFF, 8'h51, 8'h00}, '{1'h0, 8'hFF, 8'h00, 8'h11},
    '{1'h1, 8'hFF, 8'h01, 8'h00}, '{1'h0, 8'hFF, 8'h00, 8'h01}};

  rwsc_ctrl #(.LOCK_CYC(LK), .SEMI_WAIT_CYC(SW), .WDOG_CYC(WD), .WDOG_HOLD_CYC(HD),
    .SETTLE_CYC(ST)) dut_u (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .usb_bus_reset(usb_bus_reset),
    .usb_activity(usb_activity), .gpio_wake_irq(gpio_wake_irq), .osc_stable(osc_stable),
    .global_irq_en(global_irq_en), .bus_reset_irq_ack(bus_reset_irq_ack),
    .instr_done(instr_done), .cpu_rst(cpu_rst), .osc_en(osc_en), .blk_clk_en(blk_clk_en),
    .usb_addr_clr(usb_addr_clr), .bus_reset_irq(bus_reset_irq), .irq_hold(irq_hold));
  rwsc_fw_model model_u (.clk(clk), .nrst(nrst), .osc_en(osc_en),
    .bus_reset_irq(bus_reset_irq), .irq_hold(irq_hold), .osc_stable(osc_stable),
    .bus_reset_irq_ack(bus_reset_irq_ack), .instr_done(instr_done));

  // ********************************************************************
  // Clock, timeout and shared tasks
  // ********************************************************************
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // A hang is cut short well beyond the expected run of about eight hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic summarize;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // One I/O access; read data is taken once the answering edge has landed.
  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= wr;
    io_rd <= !wr;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk);
    io_wr <= 1'h0;
    io_rd <= 1'h0;
    #1;
    rd = io_rdata;
  endtask

  task automatic wait_lvl(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Power-on reset, with the bus in reset for edges lo to hi after release.
  task automatic por(input int lo, input int hi);
    @(posedge clk);
    nrst <= 1'h0;
    global_irq_en <= 1'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      usb_bus_reset <= (n >= lo && n < hi);
      #1;
      n++;
    end while (cpu_rst !== 1'h0 && n < 500);
    @(posedge clk);
    usb_bus_reset <= 1'h0;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    {nrst, io_wr, io_rd, usb_bus_reset, usb_activity, gpio_wake_irq, global_irq_en} = 7'h00;
    {io_addr, io_wdata} = 16'h0000;
    por(0, 0);
    chk("start length", LK + SW, n);
    for (int i = 0; i < 10; i++) begin
      io(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk("table read", rows[i].exp, rd);
    end
    // The table accesses take about twenty cycles, so restart once before the timed gaps.
    io(1'h1, 8'h26, 8'h5A);
    repeat (5) begin
      repeat (WD - 20) @(posedge clk);
      io(1'h1, 8'h26, 8'h5A);
    end
    chk("restarted", 0, cpu_rst);
    wait_lvl(cpu_rst, 1'h1);
    chk("watchdog time", 1, n >= WD && n <= WD + 2);
    chk("address clear", 1, usb_addr_clr);
    wait_lvl(cpu_rst, 1'h0);
    chk("watchdog hold", HD, n);
    io(1'h0, 8'hFF, 8'h00);
    chk("watchdog status", 8'h41, rd);
    chk("reset cause", 1, rd[6] && !rd[4]);
    io(1'h0, 8'h20, 8'h00);
    chk("enable cleared", 8'h00, rd);
    // Suspend twice, waking once by bus activity and once by a GPIO interrupt.
    for (int w = 0; w < 2; w++) begin
      io(1'h1, 8'hFF, 8'h09);
      repeat (4) @(posedge clk);
      #1;
      chk("suspend stops", 0, osc_en | blk_clk_en);
      repeat (WD + 10) @(posedge clk);
      #1;
      chk("stays asleep", 0, osc_en | cpu_rst);
      @(posedge clk);
      usb_activity <= (w == 0);
      gpio_wake_irq <= (w == 1);
      #1;
      wait_lvl(blk_clk_en, 1'h1);
      chk("settle time", 1, n >= ST && n < 100);
      chk("irq held", 1, irq_hold);
      @(posedge clk);
      usb_activity <= 1'h0;
      gpio_wake_irq <= 1'h0;
      #1;
      wait_lvl(irq_hold, 1'h0);
      io(1'h0, 8'hFF, 8'h00);
      chk("resume status", 8'h01, rd);
    end
    por(0, LK - 4);
    chk("lock ignores bus", LK + SW, n);
    global_irq_en <= 1'h1;
    io(1'h1, 8'h20, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk("nothing pending", 0, bus_reset_irq);
    por(LK + 10, 500);
    chk("bus reset abort", 1, n > LK + 10 && n <= LK + 15);
    global_irq_en <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
    chk("pending masked", 0, bus_reset_irq);
    io(1'h1, 8'h20, 8'h01);
    wait_lvl(bus_reset_irq, 1'h1);
    chk("pending served", 1, n <= 4);
    wait_lvl(bus_reset_irq, 1'h0);
    chk("pending acked", 1, n <= 4);
    summarize();
  end
endmodule  // test_reset_watchdog_suspend_ctrl

bind rwsc_ctrl rwsc_ctrl_properties #(.LOCK_CYC(LOCK_CYC), .SEMI_WAIT_CYC(SEMI_WAIT_CYC),
  .WDOG_CYC(WDOG_CYC), .WDOG_HOLD_CYC(WDOG_HOLD_CYC), .SETTLE_CYC(SETTLE_CYC)) chk_u (
  .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wr(io_wr), .usb_activity(usb_activity),
  .gpio_wake_irq(gpio_wake_irq), .osc_stable(osc_stable), .global_irq_en(global_irq_en),
  .cpu_rst(cpu_rst), .osc_en(osc_en), .blk_clk_en(blk_clk_en), .usb_addr_clr(usb_addr_clr),
  .bus_reset_irq(bus_reset_irq), .irq_hold(irq_hold));
